// ===== inc/emi_pkg.sv
// shared constants and types of the external memory interface
package emi_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMING_CONTROL_ADDR = 8'h84;
  localparam logic [7:0] CONFIGURATION_ADDR  = 8'h85;
  localparam logic [7:0] TIMING_CONTROL_RST  = 8'hFF;
  localparam logic [7:0] CONFIGURATION_RST   = 8'h03;
  // bits 7 and 5 of the configuration register read as zero
  localparam logic [7:0] CONFIGURATION_WMASK = 8'h5F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int USB_WINDOW_BIT  = 6;
  localparam int PIN_MUX_BIT     = 4;
  localparam int MEM_MODE_LSB    = 2;
  localparam int LATCH_WIDTH_LSB = 0;
  localparam int SETUP_LSB       = 6;
  localparam int STROBE_LSB      = 2;
  localparam int HOLD_LSB        = 0;

  // on-chip data space boundary for the split modes
  localparam logic [15:0] ONCHIP_BOUNDARY = 16'h1000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INTERNAL = 2'h0,
    MODE_SPLIT_NB = 2'h1,
    MODE_SPLIT_B  = 2'h2,
    MODE_OFFCHIP  = 2'h3
  } emi_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ALE_HI = 3'h1,
    ST_ALE_LO = 3'h2,
    ST_SETUP  = 3'h3,
    ST_STROBE = 3'h4,
    ST_HOLD   = 3'h5,
    ST_DONE   = 3'h6
  } emi_state_t;

  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data;
    logic       wr_n;
    logic       rd_n;
    logic       ale;
  } emi_pins_t;

endpackage : emi_pkg

// ===== hdl/emi_core.sv
// external memory interface: register pair, pin ownership and access sequencer
//
// Operation
// - The pins are claimed only while an off-chip external data move is in progress.
// - When the move ends every pin goes back to the value of its port latch.
// - The data drivers are switched off while the data pins serve as inputs in a read.
// - Open-drain or push-pull setting of the pins is never touched by this block.
// - A configuration bit picks multiplexed address/data with a latch strobe or separate pins.
// - A two-bit mode field picks internal only, split, split with bank select or off-chip only.
// - In multiplexed mode the latch strobe is high and then low for the latch field plus one cycles.
// - The address is stable for the setup field in cycles before the read or write strobe.
// - The read or write strobe is low for the strobe field plus one cycles.
// - The address stays valid for the hold field in cycles after the strobe ends.
`timescale 1ns/1ns
`default_nettype none

module emi_core (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic [7:0]        i_sfr_addr,
  input  wire logic              i_sfr_wr,
  input  wire logic [7:0]        i_sfr_wdata,
  output logic      [7:0]        o_sfr_rdata,
  input  wire logic              i_xdm_req,
  input  wire logic              i_xdm_write,
  input  wire logic              i_xdm_short,
  input  wire logic [15:0]       i_xdm_addr,
  input  wire logic [7:0]        i_xdm_page,
  input  wire logic [7:0]        i_xdm_wdata,
  output logic                   o_xdm_done,
  output logic                   o_xdm_local,
  output logic      [7:0]        o_xdm_rdata,
  input  wire emi_pkg::emi_pins_t i_port_latch,
  input  wire logic [7:0]        i_data_pin,
  output emi_pkg::emi_pins_t     o_pins,
  output logic                   o_data_oe,
  output logic                   o_pin_claim,
  output logic                   o_usb_buffer_window_enable
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]          timing_control_reg;
  logic [7:0]          configuration_reg;
  emi_pkg::emi_state_t state_reg;
  emi_pkg::emi_state_t state_next;
  logic [3:0]          cnt_reg;
  logic [15:0]         addr_reg;
  logic [7:0]          wdata_reg;
  logic                wr_reg;
  logic                mux_reg;
  logic [1:0]          ale_w_reg;
  logic [1:0]          setup_reg;
  logic [3:0]          strobe_reg;
  logic [1:0]          hold_reg;
  logic [7:0]          din_meta_reg;
  logic [7:0]          din_sync_reg;

  // current access fields: live in idle, snapshot afterwards
  logic [15:0]         addr_cur;
  logic                wr_cur;
  logic                mux_cur;
  logic [1:0]          ale_w_cur;
  logic [1:0]          setup_cur;
  logic [3:0]          strobe_cur;
  logic [1:0]          hold_cur;
  logic [15:0]         req_addr;
  logic                req_local;
  logic                busy_next;
  emi_pkg::emi_mode_t  mode;

  function automatic logic is_busy(input emi_pkg::emi_state_t s);
    is_busy = (s != emi_pkg::ST_IDLE) && (s != emi_pkg::ST_DONE);
  endfunction : is_busy

  // first counter value of a phase; a phase lasts its value plus one
  function automatic logic [3:0] phase_load(input emi_pkg::emi_state_t s, input logic [1:0] aw,
                                            input logic [1:0] su, input logic [3:0] sw,
                                            input logic [1:0] ho);
    case (s)
      emi_pkg::ST_ALE_HI: phase_load = {2'h0, aw};
      emi_pkg::ST_ALE_LO: phase_load = {2'h0, aw};
      emi_pkg::ST_SETUP:  phase_load = {2'h0, su} - 4'h1;
      emi_pkg::ST_STROBE: phase_load = sw;
      emi_pkg::ST_HOLD:   phase_load = {2'h0, ho} - 4'h1;
      default:            phase_load = 4'h0;
    endcase
  endfunction : phase_load

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      timing_control_reg <= emi_pkg::TIMING_CONTROL_RST;
      configuration_reg  <= emi_pkg::CONFIGURATION_RST;
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == emi_pkg::TIMING_CONTROL_ADDR) begin
        timing_control_reg <= i_sfr_wdata;
      end
      if (i_sfr_addr == emi_pkg::CONFIGURATION_ADDR) begin
        configuration_reg <= i_sfr_wdata & emi_pkg::CONFIGURATION_WMASK;
      end
    end
  end

  // read data follows the addressed register one cycle later; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_addr == emi_pkg::TIMING_CONTROL_ADDR) begin
      o_sfr_rdata <= timing_control_reg;
    end else if (i_sfr_addr == emi_pkg::CONFIGURATION_ADDR) begin
      o_sfr_rdata <= configuration_reg;
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  assign o_usb_buffer_window_enable = configuration_reg[emi_pkg::USB_WINDOW_BIT];

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign mode = emi_pkg::emi_mode_t'(configuration_reg[emi_pkg::MEM_MODE_LSB +: 2]);

  always_comb begin
    req_addr = i_xdm_addr;
    if (i_xdm_short) begin
      req_addr[15:8] = (mode == emi_pkg::MODE_SPLIT_NB) ? i_port_latch.addr_hi : i_xdm_page;
    end
    case (mode)
      emi_pkg::MODE_INTERNAL: req_local = 1'b1;
      emi_pkg::MODE_SPLIT_NB: req_local = req_addr < emi_pkg::ONCHIP_BOUNDARY;
      emi_pkg::MODE_SPLIT_B:  req_local = req_addr < emi_pkg::ONCHIP_BOUNDARY;
      default:                req_local = 1'b0;
    endcase
  end

  // timing fields are frozen for the whole access so a mid-access write cannot tear it
  always_comb begin
    if (state_reg == emi_pkg::ST_IDLE) begin
      addr_cur   = req_addr;
      wr_cur     = i_xdm_write;
      mux_cur    = ~configuration_reg[emi_pkg::PIN_MUX_BIT];
      ale_w_cur  = configuration_reg[emi_pkg::LATCH_WIDTH_LSB +: 2];
      setup_cur  = timing_control_reg[emi_pkg::SETUP_LSB +: 2];
      strobe_cur = timing_control_reg[emi_pkg::STROBE_LSB +: 4];
      hold_cur   = timing_control_reg[emi_pkg::HOLD_LSB +: 2];
    end else begin
      addr_cur   = addr_reg;
      wr_cur     = wr_reg;
      mux_cur    = mux_reg;
      ale_w_cur  = ale_w_reg;
      setup_cur  = setup_reg;
      strobe_cur = strobe_reg;
      hold_cur   = hold_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      addr_reg   <= 16'h0000;
      wdata_reg  <= 8'h00;
      wr_reg     <= 1'b0;
      mux_reg    <= 1'b0;
      ale_w_reg  <= 2'h0;
      setup_reg  <= 2'h0;
      strobe_reg <= 4'h0;
      hold_reg   <= 2'h0;
    end else if (state_reg == emi_pkg::ST_IDLE && i_xdm_req) begin
      addr_reg   <= addr_cur;
      wdata_reg  <= i_xdm_wdata;
      wr_reg     <= wr_cur;
      mux_reg    <= mux_cur;
      ale_w_reg  <= ale_w_cur;
      setup_reg  <= setup_cur;
      strobe_reg <= strobe_cur;
      hold_reg   <= hold_cur;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // phase order
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      emi_pkg::ST_IDLE: begin
        if (i_xdm_req && !req_local) begin
          // latch phases only in multiplexed mode
          if (mux_cur) begin
            state_next = emi_pkg::ST_ALE_HI;
          end else if (setup_cur != 2'h0) begin
            state_next = emi_pkg::ST_SETUP;
          end else begin
            state_next = emi_pkg::ST_STROBE;
          end
        end
      end
      emi_pkg::ST_ALE_HI: if (cnt_reg == 4'h0) state_next = emi_pkg::ST_ALE_LO;
      emi_pkg::ST_ALE_LO: begin
        if (cnt_reg == 4'h0) begin
          state_next = (setup_cur != 2'h0) ? emi_pkg::ST_SETUP : emi_pkg::ST_STROBE;
        end
      end
      emi_pkg::ST_SETUP:  if (cnt_reg == 4'h0) state_next = emi_pkg::ST_STROBE;
      emi_pkg::ST_STROBE: begin
        if (cnt_reg == 4'h0) begin
          state_next = (hold_cur != 2'h0) ? emi_pkg::ST_HOLD : emi_pkg::ST_DONE;
        end
      end
      emi_pkg::ST_HOLD:   if (cnt_reg == 4'h0) state_next = emi_pkg::ST_DONE;
      emi_pkg::ST_DONE:   state_next = emi_pkg::ST_IDLE;
      default:            state_next = emi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= emi_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= 4'h0;
    end else if (state_next != state_reg) begin
      cnt_reg <= phase_load(state_next, ale_w_cur, setup_cur, strobe_cur, hold_cur);
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_xdm_done  <= 1'b0;
      o_xdm_local <= 1'b0;
    end else begin
      o_xdm_done  <= state_next == emi_pkg::ST_DONE;
      o_xdm_local <= state_reg == emi_pkg::ST_IDLE && i_xdm_req && req_local;
    end
  end

  // ----------------------------------------------------------------
  // read data capture
  // ----------------------------------------------------------------
  // the two-stage sync means the captured byte is the bus two cycles before the strobe ends
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end else begin
      din_meta_reg <= i_data_pin;
      din_sync_reg <= din_meta_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_xdm_rdata <= 8'h00;
    end else if (state_reg == emi_pkg::ST_STROBE && cnt_reg == 4'h0 && !wr_reg) begin
      o_xdm_rdata <= din_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign busy_next = is_busy(state_next);

  // only levels and data enable leave here; output mode stays with the port
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pins      <= '1;
      o_data_oe   <= 1'b0;
      o_pin_claim <= 1'b0;
    end else begin
      // claim only while busy, latch values otherwise
      o_pin_claim     <= busy_next;
      o_pins          <= i_port_latch;
      if (busy_next) begin
        o_pins.addr_hi <= addr_cur[15:8];
        o_pins.wr_n    <= !(state_next == emi_pkg::ST_STROBE && wr_cur);
        o_pins.rd_n    <= !(state_next == emi_pkg::ST_STROBE && !wr_cur);
        if (!mux_cur) begin
          o_pins.addr_lo <= addr_cur[7:0];
        end else begin
          o_pins.ale <= state_next == emi_pkg::ST_ALE_HI;
        end
        if (state_next == emi_pkg::ST_ALE_HI || state_next == emi_pkg::ST_ALE_LO) begin
          o_pins.data <= addr_cur[7:0];
        end else begin
          o_pins.data <= (state_reg == emi_pkg::ST_IDLE) ? i_xdm_wdata : wdata_reg;
        end
      end
      o_data_oe <= busy_next && (wr_cur || state_next == emi_pkg::ST_ALE_HI
                                 || state_next == emi_pkg::ST_ALE_LO);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] strobe_len;
  logic [2:0] ale_hi_len;
  logic [2:0] ale_lo_len;
  logic [2:0] setup_len;
  logic [2:0] hold_len;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      strobe_len <= 5'h00;
      ale_hi_len <= 3'h0;
      ale_lo_len <= 3'h0;
      setup_len  <= 3'h0;
      hold_len   <= 3'h0;
    end else begin
      strobe_len <= (o_pin_claim && !(o_pins.wr_n && o_pins.rd_n)) ? strobe_len + 5'h01 : 5'h00;
      ale_hi_len <= (o_pin_claim && o_pins.ale) ? ale_hi_len + 3'h1 : 3'h0;
      ale_lo_len <= (state_reg == emi_pkg::ST_ALE_LO) ? ale_lo_len + 3'h1 : 3'h0;
      setup_len  <= (state_reg == emi_pkg::ST_SETUP) ? setup_len + 3'h1 : 3'h0;
      hold_len   <= (state_reg == emi_pkg::ST_HOLD) ? hold_len + 3'h1 : 3'h0;
    end
  end

  sequence s_strobe_start;
    (state_reg != emi_pkg::ST_STROBE) ##1 (state_reg == emi_pkg::ST_STROBE);
  endsequence

  sequence s_strobe_end;
    (state_reg == emi_pkg::ST_STROBE) ##1 (state_reg != emi_pkg::ST_STROBE);
  endsequence

  property p_claim_busy;
    @(posedge i_clk) disable iff (i_srst) o_pin_claim |-> is_busy(state_reg);
  endproperty
  a_claim_busy: assert property (p_claim_busy) else $error("pins claimed outside an access");

  property p_release;
    @(posedge i_clk) disable iff (i_srst)
      (state_reg == emi_pkg::ST_DONE) |-> !o_pin_claim && o_pins == $past(i_port_latch);
  endproperty
  a_release: assert property (p_release) else $error("pins not returned to latches");

  property p_read_off;
    @(posedge i_clk) disable iff (i_srst) (o_pin_claim && !o_pins.rd_n) |-> !o_data_oe;
  endproperty
  a_read_off: assert property (p_read_off) else $error("data driven during read");

  property p_ale_mux;
    @(posedge i_clk) disable iff (i_srst) (o_pin_claim && !mux_reg) |-> o_pins.ale == i_port_latch.ale
      || $past(i_port_latch.ale) == o_pins.ale;
  endproperty
  a_ale_mux: assert property (p_ale_mux) else $error("latch strobe in non-multiplexed mode");

  property p_local;
    @(posedge i_clk) disable iff (i_srst)
      (state_reg == emi_pkg::ST_IDLE && i_xdm_req && mode == emi_pkg::MODE_INTERNAL)
      |-> ##1 o_xdm_local && state_reg == emi_pkg::ST_IDLE;
  endproperty
  a_local: assert property (p_local) else $error("internal mode went off-chip");

  property p_ale_width;
    @(posedge i_clk) disable iff (i_srst)
      (state_reg == emi_pkg::ST_ALE_LO && $past(state_reg) == emi_pkg::ST_ALE_HI)
      |-> ale_hi_len == {1'b0, ale_w_reg} + 3'h1;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("latch high phase length wrong");

  property p_ale_low;
    @(posedge i_clk) disable iff (i_srst)
      ($past(state_reg) == emi_pkg::ST_ALE_LO && state_reg != emi_pkg::ST_ALE_LO)
      |-> ale_lo_len == {1'b0, ale_w_reg} + 3'h1;
  endproperty
  a_ale_low: assert property (p_ale_low) else $error("latch low phase length wrong");

  property p_setup;
    @(posedge i_clk) disable iff (i_srst) s_strobe_start |-> setup_len == {1'b0, setup_reg};
  endproperty
  a_setup: assert property (p_setup) else $error("address setup length wrong");

  property p_strobe;
    @(posedge i_clk) disable iff (i_srst)
      s_strobe_end |-> strobe_len == {1'b0, strobe_reg} + 5'h01;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width wrong");

  property p_hold;
    @(posedge i_clk) disable iff (i_srst)
      s_strobe_end ##[0:3] (state_reg == emi_pkg::ST_DONE) |-> hold_len == {1'b0, hold_reg}
      && $past(o_pins.addr_hi) == addr_reg[15:8];
  endproperty
  a_hold: assert property (p_hold) else $error("address hold wrong");

  property p_order;
    @(posedge i_clk) disable iff (i_srst)
      s_strobe_start |-> $past(state_reg) inside {emi_pkg::ST_IDLE, emi_pkg::ST_ALE_LO, emi_pkg::ST_SETUP};
  endproperty
  a_order: assert property (p_order) else $error("strobe entered out of order");

endmodule : emi_core

`default_nettype wire

// ===== verif/emi_mem_model.sv
// behavioural off-chip asynchronous memory on the interface pins
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model #(
  parameter int ACCESS_NS = 3
) (
  input  wire logic               i_clk,
  input  wire logic               i_mux,
  input  wire emi_pkg::emi_pins_t i_pins,
  output logic [7:0]              o_data
);
  logic [7:0]  mem [logic [15:0]];
  logic [7:0]  lo_reg = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [15:0] addr;

  assign addr = {i_pins.addr_hi, i_mux ? lo_reg : i_pins.addr_lo};

  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  // low byte taken while latch strobe high
  always @(negedge i_clk) begin
    if (i_mux && i_pins.ale) lo_reg <= i_pins.data;
    if (!i_pins.wr_n) mem[addr] = i_pins.data;
  end

  // ------------------------------------------------------------
  // read answer
  // ------------------------------------------------------------
  // released bus shows no stale byte, so a late sample cannot pass by luck
  always @(i_pins or addr) begin
    #ACCESS_NS;
    if (!i_pins.rd_n) begin
      last = mem.exists(addr) ? mem[addr] : ~last;
      o_data = last;
    end else begin
      o_data = ~last;
    end
  end
endmodule : emi_mem_model
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench of the external memory interface core
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  tc;
    logic        wr;
    logic        sh;
    logic [15:0] addr;
    logic [7:0]  page;
    logic [7:0]  data;
  } emi_row_t;

  logic               i_clk, i_srst, i_sfr_wr, i_xdm_req, i_xdm_write, i_xdm_short, mux;
  logic [7:0]         i_sfr_addr, i_sfr_wdata, i_xdm_page, i_xdm_wdata, i_data_pin;
  logic [7:0]         o_sfr_rdata, o_xdm_rdata;
  logic [15:0]        i_xdm_addr;
  logic               o_xdm_done, o_xdm_local, o_data_oe, o_pin_claim, o_usb_buffer_window_enable;
  emi_pkg::emi_pins_t i_port_latch, o_pins;
  int                 num_errors, check_count, cyc;
  logic [7:0]         exp_mem [logic [15:0]];
  emi_row_t           rows [10] = '{
    '{8'h10, 8'h45, 1'b1, 1'b0, 16'h2000, 8'h00, 8'h11}, '{8'h1C, 8'h45, 1'b1, 1'b0, 16'h2345, 8'h00, 8'hA5},
    '{8'h1C, 8'h49, 1'b0, 1'b0, 16'h2345, 8'h00, 8'h00}, '{8'h0F, 8'hFF, 1'b1, 1'b0, 16'h3456, 8'h00, 8'h5A},
    '{8'h0F, 8'hFF, 1'b0, 1'b0, 16'h3456, 8'h00, 8'h00}, '{8'h04, 8'h00, 1'b0, 1'b0, 16'h0800, 8'h00, 8'h00},
    '{8'h04, 8'h00, 1'b1, 1'b0, 16'h1800, 8'h00, 8'h3C}, '{8'h08, 8'h08, 1'b0, 1'b0, 16'h1800, 8'h00, 8'h00},
    '{8'h14, 8'h49, 1'b1, 1'b1, 16'h0077, 8'h00, 8'h99}, '{8'h18, 8'h49, 1'b0, 1'b1, 16'h0077, 8'hFF, 8'h00}};

  emi_core uut (.i_clk(i_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_xdm_req(i_xdm_req), .i_xdm_write(i_xdm_write),
    .i_xdm_short(i_xdm_short), .i_xdm_addr(i_xdm_addr), .i_xdm_page(i_xdm_page), .i_xdm_wdata(i_xdm_wdata),
    .o_xdm_done(o_xdm_done), .o_xdm_local(o_xdm_local), .o_xdm_rdata(o_xdm_rdata),
    .i_port_latch(i_port_latch), .i_data_pin(i_data_pin), .o_pins(o_pins), .o_data_oe(o_data_oe),
    .o_pin_claim(o_pin_claim), .o_usb_buffer_window_enable(o_usb_buffer_window_enable));
  emi_mem_model u_mem (.i_clk(i_clk), .i_mux(mux), .i_pins(o_pins), .o_data(i_data_pin));

  always #5 i_clk = ~i_clk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    @(posedge i_clk);
    @(negedge i_clk);
    d = o_sfr_rdata;
  endtask : sfr_read

  task automatic start_move(input emi_row_t r);
    @(posedge i_clk);
    i_xdm_req <= 1'b1;
    i_xdm_write <= r.wr;
    i_xdm_short <= r.sh;
    i_xdm_addr <= r.addr;
    i_xdm_page <= r.page;
    i_xdm_wdata <= r.data;
    @(posedge i_clk);
    i_xdm_req <= 1'b0;
  endtask : start_move

  task automatic run_row(input emi_row_t r);
    logic [15:0] ea;
    logic        loc, seen;
    int          a, s, w, h, pre, n_ale, n_pre, n_str, n_post, n_cl, n_bad;
    a = r.cfg[1:0];
    s = r.tc[7:6];
    w = r.tc[5:2];
    h = r.tc[1:0];
    mux = !r.cfg[4];
    pre = mux ? a + 1 : 0;
    ea = r.sh ? {(r.cfg[3:2] == 2'h1) ? i_port_latch.addr_hi : r.page, r.addr[7:0]} : r.addr;
    loc = (r.cfg[3:2] == 2'h0) || (r.cfg[3:2] != 2'h3 && ea < 16'h1000);
    {n_ale, n_pre, n_str, n_post, n_cl, n_bad} = '0;
    seen = 1'b0;
    sfr_write(8'h85, r.cfg);
    sfr_write(8'h84, r.tc);
    start_move(r);
    for (int i = 0; i < 60 && !seen; i++) begin
      @(negedge i_clk);
      seen = o_xdm_done | o_xdm_local;
      if (o_pin_claim) begin
        n_cl++;
        if (o_pins.addr_hi !== ea[15:8] || (!mux && o_pins.addr_lo !== ea[7:0])) n_bad++;
        if ((r.wr ? o_pins.rd_n : o_pins.wr_n) !== 1'b1 || (r.wr && o_data_oe !== 1'b1)) n_bad++;
        if (mux && o_pins.ale === 1'b1) n_ale++;
        else if ((r.wr ? o_pins.wr_n : o_pins.rd_n) === 1'b0) begin
          n_str++;
          if ((!r.wr && o_data_oe !== 1'b0) || (r.wr && o_pins.data !== r.data)) n_bad++;
        end else if (n_str == 0) n_pre++;
        else n_post++;
      end
    end
    `CHK("local", loc, o_xdm_local)
    `CHK("done", !loc, o_xdm_done)
    if (loc) `CHK("no claim", 0, n_cl)
    else begin
      `CHK("claim cycles", 2 * pre + s + w + 1 + h, n_cl)
      `CHK("latch high", pre, n_ale)
      `CHK("setup", pre + s, n_pre)
      `CHK("strobe", w + 1, n_str)
      `CHK("hold", h, n_post)
      `CHK("pin faults", 0, n_bad)
      `CHK("released", i_port_latch, o_pins)
      `CHK("oe off", 1'b0, o_data_oe)
      if (r.wr) exp_mem[ea] = r.data;
      else `CHK("read data", exp_mem[ea], o_xdm_rdata)
    end
  endtask : run_row

  // ------------------------------------------------------------
  // watchdog and main sequence
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      end_of_test();
    end
  end

  initial begin
    logic [7:0] rd;
    {i_clk, i_sfr_wr, i_xdm_req, i_xdm_write, i_xdm_short, mux} = '0;
    {i_sfr_addr, i_sfr_wdata, i_xdm_page, i_xdm_wdata, i_xdm_addr} = '0;
    {num_errors, check_count, cyc} = '0;
    // strobe pins parked high between moves, data pins only until the pattern below
    i_port_latch = '1;
    i_srst = 1'b1;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    sfr_read(8'h84, rd);
    `CHK("timing reset", 8'hFF, rd)
    sfr_read(8'h85, rd);
    `CHK("config reset", 8'h03, rd)
    `CHK("idle pins", i_port_latch, o_pins)
    // park at a pattern that differs from the reset levels, so a release to them would show
    @(posedge i_clk);
    i_port_latch <= {8'hFF, 8'h5A, 8'h96, 3'b110};
    sfr_write(8'h85, 8'hFF);
    sfr_read(8'h85, rd);
    `CHK("config mask", 8'h5F, rd)
    `CHK("usb window", 1'b1, o_usb_buffer_window_enable)
    sfr_write(8'h40, 8'h12);
    sfr_read(8'h40, rd);
    `CHK("unmapped", 8'h00, rd)
    for (int i = 0; i < 10; i++) run_row(rows[i]);
    // reset in the middle of a long access must free the pins at once
    sfr_write(8'h85, 8'h1C);
    sfr_write(8'h84, 8'hFD);
    start_move(rows[1]);
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK("reset claim", 1'b0, o_pin_claim)
    `CHK("reset pins", {27{1'b1}}, o_pins)
    @(posedge i_clk);
    i_srst <= 1'b0;
    sfr_read(8'h84, rd);
    `CHK("timing after reset", 8'hFF, rd)
    run_row(rows[1]);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
